// *** design/isac_consts.vh ***
/*
 * Constants of the info-region and SRAM access controller: address
 * windows, info page offsets, split reset value, size and state codes.
 * Assumes a single system bus clock and byte-addressed 32-bit data.
 */
// Summary of operation
// - info region decodes at 0x4000_0c00 to 0x4000_0fff.
// - direct bus writes never change any info location.
// - info region is two 512-byte pages, page zero below page one.
// - program or erase commands aimed at info page zero are refused.
// - info page one reads back exactly what page zero holds.
// - offset 0xc4 holds the reference current in nanoamperes.
// - offset 0xc8 holds the reference voltage in millivolts.
// - offset 0xcc holds temperature sensor voltage at 27 degrees in millivolts.
// - offsets 0xd0 to 0xdc hold high-side switch one to four sense ratios.
// - offsets 0xe0 to 0xfc hold half-bridge sense ratios, high then low side.
// - 2 KB SRAM decodes at 0x2000_0000 to 0x2000_07ff.
// - SRAM takes byte, half-word and word accesses, writing only addressed lanes.
// - with the remap select set, SRAM also appears at address zero.
// - the processor reaches all of SRAM at all times.
// - debug port always reaches SRAM at or above the split boundary.
// - debug access below the split is blocked while protection is active.
// - split boundary is word aligned, loaded from flash, readable by software.
// - the readable split field drops the two always-zero address bits.
// - protected section runs from RAM base to the word before the split.
// - with the remap select clear, flash main area appears at address zero.
// - accesses to unused address space get an error response.
`ifndef ISAC_CONSTS_VH
`define ISAC_CONSTS_VH

`define ISAC_INFO_BASE 32'h4000_0c00
`define ISAC_INFO_LAST 32'h4000_0fff
`define ISAC_INFO_P0_LAST 32'h4000_0dff
`define ISAC_RAM_BASE 32'h2000_0000
`define ISAC_RAM_LAST 32'h2000_07ff
`define ISAC_RAM_ALIAS_LAST 32'h0000_07ff
`define ISAC_FLASH_BASE 32'h1000_0000
`define ISAC_FLASH_LAST 32'h1000_7fff
`define ISAC_FLASH_ALIAS_LAST 32'h0000_7fff
`define ISAC_PERIPH_BASE 32'h4000_0000
`define ISAC_PERIPH_LAST 32'h4000_1bff
`define ISAC_PPB_BASE 32'he000_0000
`define ISAC_PPB_LAST 32'he00f_ffff

`define ISAC_OFS_TRACE_LAST 9'h03c
`define ISAC_OFS_TRIM 9'h040
`define ISAC_OFS_IREF 9'h0c4
`define ISAC_OFS_VREF 9'h0c8
`define ISAC_OFS_VT27 9'h0cc
`define ISAC_OFS_HSS_FIRST 9'h0d0
`define ISAC_OFS_HSS_LAST 9'h0dc
`define ISAC_OFS_HB_FIRST 9'h0e0
`define ISAC_OFS_HB_LAST 9'h0fc
`define ISAC_INFO_RESERVED_VAL 32'h0000_0000

`define ISAC_SPLIT_RESET 9'h1ff
`define ISAC_SIZE_BYTE 2'h0
`define ISAC_SIZE_HALF 2'h1
`define ISAC_SIZE_WORD 2'h2
`define ISAC_ST_IDLE 1'h0
`define ISAC_ST_FLASH 1'h1

`endif

// *** design/isac_info_rom.v ***
/*
 * Info page contents: calibration words looked up by page offset.
 * Assumes the caller has already stripped the page-select bit.
 */
`timescale 1ns/1ps
`default_nettype none
`include "isac_consts.vh"

module isac_info_rom #(
    parameter [31:0] TRACE_WORD = 32'h0000_0000,
    parameter [31:0] TRIM_WORD = 32'h0000_0000,
    parameter [31:0] IREF_NA = 32'h0000_0000,
    parameter [31:0] VREF_MV = 32'h0000_0000,
    parameter [31:0] VT27_MV = 32'h0000_0000,
    parameter [127:0] HSS_RATIOS = 128'h0,
    parameter [255:0] HB_RATIOS = 256'h0
) (
    input wire [8:0] page_ofs,
    output reg [31:0] info_word
);

    wire [8:0] wofs;
    wire [1:0] hss_sel;
    wire [2:0] hb_sel;

    // byte reads return the enclosing word; caller picks lanes
    assign wofs = {page_ofs[8:2], 2'b00};
    assign hss_sel = page_ofs[3:2];
    assign hb_sel = page_ofs[4:2];

    // fixed layout lookup; anything unlisted is reserved
    always @* begin
        info_word = `ISAC_INFO_RESERVED_VAL;
        if (wofs <= `ISAC_OFS_TRACE_LAST)
            info_word = TRACE_WORD;
        else if (wofs == `ISAC_OFS_TRIM)
            info_word = TRIM_WORD;
        else if (wofs == `ISAC_OFS_IREF)
            info_word = IREF_NA;
        else if (wofs == `ISAC_OFS_VREF)
            info_word = VREF_MV;
        else if (wofs == `ISAC_OFS_VT27)
            info_word = VT27_MV;
        else if (wofs >= `ISAC_OFS_HSS_FIRST && wofs <= `ISAC_OFS_HSS_LAST)
            info_word = HSS_RATIOS[hss_sel*32 +: 32];
        else if (wofs >= `ISAC_OFS_HB_FIRST && wofs <= `ISAC_OFS_HB_LAST)
            info_word = HB_RATIOS[hb_sel*32 +: 32];
    end

endmodule // isac_info_rom
`default_nettype wire

// *** design/isac_mem_ctrl.v ***
/*
 * Memory-side slave for the system bus: read-only info pages, 2 KB
 * SRAM with debug protection split, address-zero remap and a default
 * slave for unused space. Flash main area accesses are forwarded.
 * Assumes one master request at a time, write data already placed on
 * its byte lanes, and protection state and split word from the flash
 * controller on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "isac_consts.vh"

module isac_mem_ctrl #(
    parameter RAM_WORDS = 512,
    parameter IDX_BITS = 9,
    parameter [31:0] INFO_IREF_NA = 32'h0000_0000,
    parameter [31:0] INFO_VREF_MV = 32'h0000_0000,
    parameter [31:0] INFO_VT27_MV = 32'h0000_0000,
    parameter [127:0] INFO_HSS_RATIOS = 128'h0,
    parameter [255:0] INFO_HB_RATIOS = 256'h0
) (
    input wire sys_clk,
    input wire rst_n,
    // system bus request
    input wire bus_req,
    input wire bus_write,
    input wire bus_debug,
    input wire [31:0] bus_addr,
    input wire [1:0] bus_size,
    input wire [31:0] bus_wdata,
    // system bus answer
    output wire bus_busy,
    output reg bus_done_r,
    output reg bus_err_r,
    output reg [31:0] bus_rdata_r,
    output wire periph_sel,
    // mapping and protection state
    input wire ram_remap_select,
    input wire protection_active,
    input wire split_load,
    input wire [31:0] split_word,
    output reg [8:0] memory_info_split_r,
    // flash controller command check
    input wire fc_cmd_valid,
    input wire [31:0] fc_cmd_addr,
    output wire fc_cmd_refuse,
    // flash main area port
    output reg flash_req_r,
    output reg flash_write_r,
    output reg [14:0] flash_addr_r,
    output reg [1:0] flash_size_r,
    output reg [31:0] flash_wdata_r,
    input wire flash_ack,
    input wire flash_err,
    input wire [31:0] flash_rdata
);

    // inclusive address window test, used by every decoder below
    function in_range;
        input [31:0] a;
        input [31:0] lo;
        input [31:0] hi;
        begin
            in_range = (a >= lo) && (a <= hi);
        end
    endfunction

    // natural alignment for the access size
    function size_aligned;
        input [1:0] sz;
        input [1:0] ofs;
        begin
            case (sz)
                `ISAC_SIZE_BYTE: size_aligned = 1'b1;
                `ISAC_SIZE_HALF: size_aligned = ~ofs[0];
                `ISAC_SIZE_WORD: size_aligned = (ofs == 2'b00);
                default: size_aligned = 1'b0;
            endcase
        end
    endfunction

    // byte lanes touched by an access
    function [3:0] lane_mask;
        input [1:0] sz;
        input [1:0] ofs;
        begin
            case (sz)
                `ISAC_SIZE_BYTE: lane_mask = 4'h1 << ofs;
                `ISAC_SIZE_HALF: lane_mask = ofs[1] ? 4'hc : 4'h3;
                `ISAC_SIZE_WORD: lane_mask = 4'hf;
                default: lane_mask = 4'h0;
            endcase
        end
    endfunction

    reg [31:0] ram_mem [0:RAM_WORDS-1];
    reg state_r;
    reg [IDX_BITS-1:0] split_r;

    // sequencer states: idle, or waiting on the flash main area port
    localparam ST_IDLE = 1'b0;
    localparam ST_FLASH = 1'b1;

    wire hit_ram_phys;
    wire hit_ram_alias;
    wire hit_ram;
    wire hit_flash_phys;
    wire hit_flash_alias;
    wire hit_flash;
    wire hit_info;
    wire [IDX_BITS-1:0] ram_idx;
    wire [3:0] lanes;
    wire aligned;
    wire dbg_blocked;
    wire ram_ok;
    wire ram_we;
    wire take;
    wire [31:0] info_word;

    // address decode; the ram window sits on a 2 KB boundary so the
    // physical and remapped views share the same word index
    assign hit_ram_phys = in_range(bus_addr, `ISAC_RAM_BASE, `ISAC_RAM_LAST);
    assign hit_ram_alias = ram_remap_select
        & in_range(bus_addr, 32'h0000_0000, `ISAC_RAM_ALIAS_LAST);
    assign hit_ram = hit_ram_phys | hit_ram_alias;
    assign hit_flash_phys = in_range(bus_addr, `ISAC_FLASH_BASE, `ISAC_FLASH_LAST);
    assign hit_flash_alias = ~ram_remap_select
        & in_range(bus_addr, 32'h0000_0000, `ISAC_FLASH_ALIAS_LAST);
    assign hit_flash = hit_flash_phys | hit_flash_alias;
    assign hit_info = in_range(bus_addr, `ISAC_INFO_BASE, `ISAC_INFO_LAST);

    // peripherals and the private bus answer for themselves
    assign periph_sel = bus_req & ~hit_info
        & (in_range(bus_addr, `ISAC_PERIPH_BASE, `ISAC_PERIPH_LAST)
        | in_range(bus_addr, `ISAC_PPB_BASE, `ISAC_PPB_LAST));

    assign ram_idx = bus_addr[IDX_BITS+1:2];
    assign lanes = lane_mask(bus_size, bus_addr[1:0]);
    assign aligned = size_aligned(bus_size, bus_addr[1:0]);

    // words strictly below the split are the protected section; the
    // processor is never checked, only the debug port
    assign dbg_blocked = bus_debug & protection_active & (ram_idx < split_r);
    assign ram_ok = aligned & ~dbg_blocked;
    assign take = bus_req & (state_r == ST_IDLE);
    assign ram_we = take & hit_ram & bus_write & ram_ok;
    assign bus_busy = (state_r != ST_IDLE);

    // the flash controller asks before it programs or erases; page
    // zero is factory data and must never be touched
    assign fc_cmd_refuse = fc_cmd_valid
        & in_range(fc_cmd_addr, `ISAC_INFO_BASE, `ISAC_INFO_P0_LAST);

    // page-select bit dropped so both pages return the same word
    isac_info_rom #(
        .TRACE_WORD(32'h0000_0000),
        .TRIM_WORD(32'h0000_0000),
        .IREF_NA(INFO_IREF_NA),
        .VREF_MV(INFO_VREF_MV),
        .VT27_MV(INFO_VT27_MV),
        .HSS_RATIOS(INFO_HSS_RATIOS),
        .HB_RATIOS(INFO_HB_RATIOS)
    ) u_info_rom (
        .page_ofs(bus_addr[8:0]),
        .info_word(info_word)
    );

    // split boundary capture; low two address bits are dropped, which
    // forces word alignment and gives the software-visible field
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            split_r <= `ISAC_SPLIT_RESET;
            memory_info_split_r <= `ISAC_SPLIT_RESET;
        end else if (split_load) begin
            split_r <= split_word[IDX_BITS+1:2];
            memory_info_split_r <= split_word[10:2];
        end
    end

    // sram byte-lane writes; no reset on the array itself
    integer lane;
    always @(posedge sys_clk) begin
        for (lane = 0; lane < 4; lane = lane + 1) begin
            if (ram_we && lanes[lane])
                ram_mem[ram_idx][lane*8 +: 8] <= bus_wdata[lane*8 +: 8];
        end
    end

    // request sequencer: local targets answer in the next cycle, the
    // flash main area holds the bus until its port acknowledges
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            bus_done_r <= 1'b0;
            bus_err_r <= 1'b0;
            bus_rdata_r <= 32'h0000_0000;
            flash_req_r <= 1'b0;
            flash_write_r <= 1'b0;
            flash_addr_r <= 15'h0000;
            flash_size_r <= 2'h0;
            flash_wdata_r <= 32'h0000_0000;
        end else begin
            bus_done_r <= 1'b0;
            flash_req_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (bus_req) begin
                        if (hit_ram) begin
                            bus_done_r <= 1'b1;
                            bus_err_r <= ~ram_ok;
                            if (!bus_write && ram_ok)
                                bus_rdata_r <= ram_mem[ram_idx];
                            else
                                bus_rdata_r <= 32'h0000_0000;
                        end else if (hit_info) begin
                            // writes are swallowed: nothing is stored
                            bus_done_r <= 1'b1;
                            bus_err_r <= 1'b0;
                            bus_rdata_r <= bus_write ? 32'h0000_0000 : info_word;
                        end else if (hit_flash) begin
                            flash_req_r <= 1'b1;
                            flash_write_r <= bus_write;
                            flash_addr_r <= bus_addr[14:0];
                            flash_size_r <= bus_size;
                            flash_wdata_r <= bus_wdata;
                            state_r <= ST_FLASH;
                        end else if (!periph_sel) begin
                            // default slave for unused space
                            bus_done_r <= 1'b1;
                            bus_err_r <= 1'b1;
                            bus_rdata_r <= 32'h0000_0000;
                        end
                    end
                end
                ST_FLASH: begin
                    if (flash_ack) begin
                        bus_done_r <= 1'b1;
                        bus_err_r <= flash_err;
                        bus_rdata_r <= flash_rdata;
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // isac_mem_ctrl
`default_nettype wire

// *** tb/isac_flash_model.sv ***
/* flash main area responder for the controller's flash port.
   assumes one outstanding request at a time; slow stretches the answer */
`timescale 1ns/1ps
`default_nettype none
module isac_flash_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic flash_req_r,
    input wire logic [14:0] flash_addr_r,
    output logic flash_ack,
    output logic flash_err,
    output logic [31:0] flash_rdata
);
    logic [2:0] cnt_r;
    logic [14:0] adr_r;
    logic [31:0] word;
    // data is a pattern of the address; inverted outside the ack cycle
    assign word = 32'h5a5a_0000 | {17'h0, adr_r};
    assign flash_rdata = flash_ack ? word : ~word;
    assign flash_err = 1'b0;
    // count down to a one-cycle ack
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 3'h0;
            adr_r <= 15'h0;
            flash_ack <= 1'b0;
        end else begin
            flash_ack <= (cnt_r == 3'h1) && !flash_req_r;
            if (flash_req_r) begin
                cnt_r <= slow ? 3'h4 : 3'h1;
                adr_r <= flash_addr_r;
            end else if (cnt_r != 3'h0) begin
                cnt_r <= cnt_r - 3'h1;
            end
        end
    end
endmodule // isac_flash_model
`default_nettype wire

// *** tb/isac_mem_ctrl_checker.sv ***
/* bus answer, protection and split checks on the controller's ports.
   assumes one clock sys_clk and async active-low rst_n */
`timescale 1ns/1ps
`default_nettype none
module isac_mem_ctrl_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic bus_req,
    input wire logic bus_write,
    input wire logic bus_debug,
    input wire logic [31:0] bus_addr,
    input wire logic [1:0] bus_size,
    input wire logic bus_busy,
    input wire logic bus_done_r,
    input wire logic bus_err_r,
    input wire logic [31:0] bus_rdata_r,
    input wire logic ram_remap_select,
    input wire logic protection_active,
    input wire logic split_load,
    input wire logic [31:0] split_word,
    input wire logic [8:0] memory_info_split_r,
    input wire logic fc_cmd_valid,
    input wire logic [31:0] fc_cmd_addr,
    input wire logic fc_cmd_refuse,
    input wire logic flash_req_r,
    input wire logic [14:0] flash_addr_r
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire tk = bus_req && !bus_busy;
    wire ram = bus_addr[31:11] == 21'h040000;
    wire wrd = bus_size == 2'h2 && bus_addr[1:0] == 2'h0;
    // refuse flag, taken request classes and their answers, split load and busy checks
    refuse_page0_a: assert property (fc_cmd_refuse == (fc_cmd_valid &&
        fc_cmd_addr[31:9] == 23'h200006)) else $error("refuse flag wrong");
    ram_answer_a: assert property (tk && ram |=> bus_done_r)
        else $error("ram access not answered");
    cpu_ram_ok_a: assert property (tk && ram && !bus_debug && wrd |=> !bus_err_r)
        else $error("cpu ram access refused");
    dbg_block_a: assert property (tk && ram && bus_debug && protection_active &&
        bus_addr[10:2] < memory_info_split_r |=> bus_done_r && bus_err_r && bus_rdata_r == 0)
        else $error("debug below split not blocked");
    dbg_upper_a: assert property (tk && ram && bus_debug && wrd &&
        bus_addr[10:2] >= memory_info_split_r |=> !bus_err_r) else $error("upper blocked");
    info_wr_ok_a: assert property (tk && bus_write && bus_addr[31:10] == 22'h100003
        |=> bus_done_r && !bus_err_r) else $error("info write not clean");
    unmapped_err_a: assert property (tk && bus_addr[31:11] == 21'h040001
        |=> bus_done_r && bus_err_r) else $error("unmapped access no error");
    split_load_a: assert property (split_load
        |=> memory_info_split_r == $past(split_word[10:2])) else $error("split not loaded");
    flash_zero_a: assert property (tk && !ram_remap_select && bus_addr[31:15] == 0
        |=> flash_req_r && flash_addr_r == $past(bus_addr[14:0])) else $error("no flash fwd");
    remap_ram_a: assert property (tk && ram_remap_select && bus_addr[31:11] == 0
        |=> bus_done_r && !flash_req_r) else $error("alias ram not answered");
    flash_busy_a: assert property (flash_req_r |-> bus_busy)
        else $error("busy low during flash access");
endmodule // isac_mem_ctrl_checker
bind isac_mem_ctrl isac_mem_ctrl_checker u_chk (.sys_clk, .rst_n, .bus_req, .bus_write,
    .bus_debug, .bus_addr, .bus_size, .bus_busy, .bus_done_r, .bus_err_r, .bus_rdata_r,
    .ram_remap_select, .protection_active, .split_load, .split_word, .memory_info_split_r,
    .fc_cmd_valid, .fc_cmd_addr, .fc_cmd_refuse, .flash_req_r, .flash_addr_r);
`default_nettype wire

// *** tb/isac_mem_ctrl_tb.sv ***
/* self-checking bench for isac_mem_ctrl with a flash responder.
   assumes the bus answers within 20 cycles */
`timescale 1ns/1ps
`default_nettype none
module isac_mem_ctrl_tb;
    localparam logic [127:0] HSS = 128'h00000104_00000103_00000102_00000101;
    localparam logic [255:0] HB = 256'h00000208_00000207_00000206_00000205_00000204_00000203_00000202_00000201;
    localparam logic [479:0] CAL = {HB, HSS, 32'h0000_0258, 32'h0000_04b0, 32'h0000_2710};
    logic sys_clk, rst_n, bus_req, bus_write, bus_debug, bus_busy, bus_done_r, bus_err_r, slow;
    logic ram_remap_select, protection_active, split_load, fc_cmd_valid, fc_cmd_refuse;
    logic flash_req_r, flash_write_r, flash_ack, flash_err, periph_sel;
    logic [31:0] bus_addr, bus_wdata, bus_rdata_r, split_word, fc_cmd_addr, flash_rdata;
    logic [31:0] flash_wdata_r, rd, er;
    logic [1:0] bus_size, flash_size_r;
    logic [8:0] memory_info_split_r;
    logic [14:0] flash_addr_r;
    int error_cnt, comparisons, cyc;
    isac_mem_ctrl #(.INFO_IREF_NA(CAL[31:0]), .INFO_VREF_MV(CAL[63:32]),
        .INFO_VT27_MV(CAL[95:64]), .INFO_HSS_RATIOS(HSS), .INFO_HB_RATIOS(HB)) DUT (.sys_clk,
        .rst_n, .bus_req, .bus_write, .bus_debug, .bus_addr, .bus_size, .bus_wdata, .bus_busy,
        .bus_done_r, .bus_err_r, .bus_rdata_r, .periph_sel, .ram_remap_select,
        .protection_active, .split_load, .split_word, .memory_info_split_r, .fc_cmd_valid,
        .fc_cmd_addr, .fc_cmd_refuse, .flash_req_r, .flash_write_r, .flash_addr_r,
        .flash_size_r, .flash_wdata_r, .flash_ack, .flash_err, .flash_rdata);
    isac_flash_model u_fm (.sys_clk, .rst_n, .slow, .flash_req_r, .flash_addr_r, .flash_ack,
        .flash_err, .flash_rdata);
    task automatic conclude();
        if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %0t got %h want %h", $time, g, e);
        end
    endtask
    // one bus transfer: request held one cycle, answer awaited at falling edges
    task automatic xfer(input logic w, d, input logic [31:0] a, input logic [1:0] s,
        input logic [31:0] wd);
        int n = 0;
        @(negedge sys_clk);
        {bus_req, bus_write, bus_debug, bus_addr, bus_size, bus_wdata} = {1'b1, w, d, a, s, wd};
        @(negedge sys_clk);
        bus_req = 1'b0;
        while (bus_done_r !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        chk({31'h0, bus_done_r}, 32'h1);
        rd = bus_rdata_r;
        er = {31'h0, bus_err_r};
    endtask
    task automatic t_ram();
        xfer(1, 0, 32'h2000_0010, 2'h2, 32'h1122_3344);
        xfer(1, 0, 32'h2000_0011, 2'h0, 32'h0000_aa00);
        xfer(1, 0, 32'h2000_0012, 2'h1, 32'hbeef_0000);
        xfer(0, 0, 32'h2000_0010, 2'h2, 0);
        chk(rd, 32'hbeef_aa44);
        xfer(1, 0, 32'h2000_07fc, 2'h2, 32'h0bad_cafe);
        xfer(0, 0, 32'h2000_07fc, 2'h2, 0);
        chk(rd, 32'h0bad_cafe);
        xfer(0, 0, 32'h2000_0800, 2'h2, 0);
        chk(er, 32'h1);
        ram_remap_select = 1'b1;
        xfer(0, 0, 32'h0000_0010, 2'h2, 0);
        chk(rd, 32'hbeef_aa44);
        ram_remap_select = 1'b0;
    endtask
    // calibration words on both pages, write attempt, reserved word
    task automatic t_info();
        for (int i = 0; i < 30; i++) begin
            xfer(0, 0, 32'h4000_0cc4 + 32'(4 * (i % 15)) + (i < 15 ? 32'h0 : 32'h200), 2'h2, 0);
            chk(rd, CAL[32 * (i % 15) +: 32]);
        end
        xfer(1, 0, 32'h4000_0cc8, 2'h2, 32'hffff_ffff);
        chk(er, 32'h0);
        xfer(0, 0, 32'h4000_0cc8, 2'h0, 0);
        chk(rd, CAL[63:32]);
        xfer(0, 0, 32'h4000_0c80, 2'h2, 0);
        chk(rd, 32'h0);
    endtask
    task automatic t_split();
        @(negedge sys_clk);
        {split_word, split_load} = {32'h2000_0100, 1'b1};
        @(negedge sys_clk);
        split_load = 1'b0;
        chk({23'h0, memory_info_split_r}, 32'h40);
        xfer(1, 0, 32'h2000_00fc, 2'h2, 32'h1234_5678);
        protection_active = 1'b1;
        xfer(1, 1, 32'h2000_00fc, 2'h2, 32'hdead_beef);
        chk(er, 32'h1);
        xfer(0, 0, 32'h2000_00fc, 2'h2, 0);
        chk(rd, 32'h1234_5678);
        xfer(1, 1, 32'h2000_0100, 2'h2, 32'h5555_aaaa);
        xfer(0, 1, 32'h2000_0100, 2'h2, 0);
        chk(rd, 32'h5555_aaaa);
        protection_active = 1'b0;
        xfer(0, 1, 32'h2000_00fc, 2'h2, 0);
        chk(rd, 32'h1234_5678);
    endtask
    task automatic t_flash();
        for (int k = 0; k < 2; k++) begin
            slow = k[0];
            xfer(0, 0, 32'h0000_0040, 2'h2, 0);
            chk(rd, 32'h5a5a_0040);
        end
        // physical flash write: port registers stand until the next flash request
        xfer(1, 0, 32'h1000_0046, 2'h1, 32'h1234_0000);
        chk(er, 32'h0);
        chk({17'h0, flash_addr_r}, 32'h46);
        chk({30'h0, flash_size_r}, 32'h1);
        chk({31'h0, flash_write_r}, 32'h1);
        chk(flash_wdata_r, 32'h1234_0000);
        chk({31'h0, bus_busy}, 32'h0);
        @(negedge sys_clk);
        {fc_cmd_valid, fc_cmd_addr} = {1'b1, 32'h4000_0c10};
        #1 chk({31'h0, fc_cmd_refuse}, 32'h1);
        @(negedge sys_clk);
        fc_cmd_addr = 32'h4000_0e10;
        #1 chk({31'h0, fc_cmd_refuse}, 32'h0);
        @(negedge sys_clk);
        fc_cmd_valid = 1'b0;
        // peripheral window is left to its own slave; info is not peripheral
        {bus_req, bus_write, bus_addr} = {1'b1, 1'b0, 32'h4000_0800};
        #1 chk({31'h0, periph_sel}, 32'h1);
        @(negedge sys_clk);
        bus_addr = 32'h4000_0c10;
        #1 chk({31'h0, periph_sel | bus_done_r}, 32'h0);
        @(negedge sys_clk);
        bus_req = 1'b0;
        chk({31'h0, bus_done_r}, 32'h1);
    endtask
    // timeout well above the roughly 125 cycles the run needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            $display("mismatch %0t timeout", $time);
            conclude();
        end
    end
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        {rst_n, bus_req, bus_write, bus_debug, slow, ram_remap_select, protection_active} = 0;
        {split_load, fc_cmd_valid, bus_addr, bus_wdata, bus_size, split_word, fc_cmd_addr} = 0;
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        chk({23'h0, memory_info_split_r}, 32'h1ff);
        t_ram();
        t_info();
        t_split();
        t_flash();
        conclude();
    end
endmodule // isac_mem_ctrl_tb
`default_nettype wire
